//--- src/hbc_defs.svh
`ifndef HBC_DEFS_SVH
`define HBC_DEFS_SVH

// Object dictionary indexes reached through the configuration write port
`define HBC_IDX_CONSUMER     16'h1016
`define HBC_IDX_PRODUCER     16'h1017
`define HBC_IDX_GUARD_TIME   16'h100C
`define HBC_IDX_LIFE_FACTOR  16'h100D

// Consumer entry layout
`define HBC_CONS_COUNT       8'h04
`define HBC_CONS_NODE_MSB    23
`define HBC_CONS_NODE_LSB    16
`define HBC_CONS_TIME_MSB    15
`define HBC_CONS_TIME_LSB    0

// Reset values
`define HBC_CONS_RESET       32'h0000_0000
`define HBC_PROD_RESET       8'h00

// Heartbeat frame
`define HBC_HB_COB_BASE      11'h700

// Node state codes carried in the heartbeat byte
`define HBC_ST_STOPPED       7'h04
`define HBC_ST_OPERATIONAL   7'h05
`define HBC_ST_PREOP         7'h7F

// Least accepted heartbeat time, in ms
`define HBC_MIN_TIME_MS      16'h0002

// Tick timing
`define HBC_CLK_MHZ          100
`define HBC_TICK_US          1000
`define HBC_TICK_CYCLES      (`HBC_TICK_US * `HBC_CLK_MHZ)

`endif

//--- src/hbc_pkg.sv
package hbc_pkg;

	// Configuration write from the SDO side
	typedef struct packed {
		logic        valid;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] data;
	} hbc_cfg_t;

	// Heartbeat frame received from the bus
	typedef struct packed {
		logic       valid;
		logic [6:0] node;
	} hbc_rx_t;

	// Heartbeat frame to transmit
	typedef struct packed {
		logic        valid;
		logic [10:0] cob_id;
		logic [7:0]  data;
	} hbc_tx_t;

	// Network state as seen by this block
	typedef enum logic [1:0] {
		HBC_NMT_PREOP   = 2'b00,
		HBC_NMT_OPER    = 2'b01,
		HBC_NMT_STOPPED = 2'b10
	} hbc_nmt_t;

	// Consumer slot state
	typedef enum logic [1:0] {
		HBC_CS_OFF   = 2'b00,
		HBC_CS_WAIT  = 2'b01,
		HBC_CS_RUN   = 2'b10,
		HBC_CS_FAULT = 2'b11
	} hbc_cs_t;

endpackage

//--- src/hbc_ms_tick.sv
`timescale 1ns/1ps
`include "hbc_defs.svh"

// Divides the system clock down to a one-cycle pulse every millisecond
module hbc_ms_tick
	import hbc_pkg::*;
#(
	parameter int TICK_CYCLES = `HBC_TICK_CYCLES
)
(
	input  wire logic clk,
	input  wire logic rst,
	output logic      tick
);

	logic [23:0] cnt_reg;    // Cycles since last tick

	// Free-running divider; tick is registered
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_reg <= 24'h000000;
			tick    <= 1'b0;
		end
		else if (cnt_reg == 24'(TICK_CYCLES - 1))
		begin
			cnt_reg <= 24'h000000;
			tick    <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + 24'h000001;
			tick    <= 1'b0;
		end
	end

endmodule

//--- src/hbc_heartbeat.sv
`timescale 1ns/1ps
`include "hbc_defs.svh"

// How it works
// - Four heartbeat consumer slots monitored
// - Entry: reserved, node id, ms timeout
// - Zero timeout leaves consumer disabled
// - Timing starts at first producer heartbeat
// - Timeout forces preop and raises error
// - Nonzero producer time sends periodic heartbeat
// - Frame 700h plus node, bit7 zero
// - Zero time disables that heartbeat function
// - Active in stopped, preop and operational
// - Nonzero times below 2 ms are refused
// - Heartbeat and guarding never both enabled
// - Re-enabling service clears error indication
// - Objects reset to defaults on reset
// - Producer and consumer run independently
// - States: stopped 4, operational 5, preop 127
module hbc_heartbeat
	import hbc_pkg::*;
#(
	parameter int            NUM_CONS    = 4,
	parameter int            TICK_CYCLES = `HBC_TICK_CYCLES,
	parameter logic [6:0]    NODE_ID     = 7'h01
)
(
	input  wire logic        MCLK,
	input  wire logic        SYS_RST,
	input  wire hbc_cfg_t    CFG_WR,
	input  wire hbc_rx_t     HB_RX,
	input  wire hbc_nmt_t    NMT_STATE,
	input  wire logic        TX_READY,
	output hbc_tx_t          HB_TX,
	output logic             CFG_ACK,
	output logic             CFG_NAK,
	output logic [31:0]      CFG_RDATA,
	output logic             FORCE_PREOP,
	output logic             COMM_ERROR,
	output logic [3:0]       CONS_FAULT
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Node state code for the heartbeat byte
	function automatic logic [6:0] state_code(input hbc_nmt_t s);
		case (s)
			HBC_NMT_STOPPED: state_code = `HBC_ST_STOPPED;
			HBC_NMT_OPER:    state_code = `HBC_ST_OPERATIONAL;
			default:         state_code = `HBC_ST_PREOP;
		endcase
	endfunction

	// A time is acceptable if zero (disable) or at least the floor
	function automatic logic time_ok(input logic [15:0] t);
		time_ok = (t == 16'h0000) || (t >= `HBC_MIN_TIME_MS);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Storage and tick

	logic [31:0]    cons_reg  [NUM_CONS];  // Consumer entries
	logic [7:0]     prod_reg;              // Producer time in ms
	logic           guard_on_reg;          // Node guarding enabled elsewhere
	hbc_cs_t        cs_reg    [NUM_CONS];  // Consumer slot state
	logic [15:0]    ccnt_reg  [NUM_CONS];  // Consumer ms counters
	logic [7:0]     pcnt_reg;              // Producer ms counter
	logic           tx_pend_reg;           // Heartbeat awaiting the CAN side
	logic           tick;                  // One-cycle millisecond pulse

	hbc_ms_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.clk  (MCLK),
		.rst  (SYS_RST),
		.tick (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Configuration decode

	logic           wr_cons;     // Valid write to a consumer subindex
	logic           wr_prod;     // Valid write to producer time
	logic           wr_guard;    // Write to a guarding object
	logic [1:0]     wr_slot;     // Target slot of a consumer write
	logic           wr_bad;      // Refused write

	// Sub-index 0 of 1016h is read-only; 1..4 select a slot
	always_comb
	begin
		wr_slot  = 2'(CFG_WR.sub - 8'h01);
		wr_cons  = 1'b0;
		wr_prod  = 1'b0;
		wr_guard = 1'b0;
		wr_bad   = 1'b0;
		if (CFG_WR.valid)
		begin
			case (CFG_WR.index)
				`HBC_IDX_CONSUMER:
				begin
					if (CFG_WR.sub >= 8'h01 && CFG_WR.sub <= `HBC_CONS_COUNT
						&& time_ok(CFG_WR.data[`HBC_CONS_TIME_MSB:`HBC_CONS_TIME_LSB]))
						wr_cons = 1'b1;
					else
						wr_bad = 1'b1;
				end
				`HBC_IDX_PRODUCER:
				begin
					if (CFG_WR.sub == 8'h00 && time_ok({8'h00, CFG_WR.data[7:0]}))
						wr_prod = 1'b1;
					else
						wr_bad = 1'b1;
				end
				`HBC_IDX_GUARD_TIME, `HBC_IDX_LIFE_FACTOR:
					wr_guard = 1'b1;
				default:
					wr_bad = 1'b1;
			endcase
		end
	end

	logic hb_any;      // Heartbeat in use before or after this write
	logic cfg_conflict; // Write would enable both services

	always_comb
	begin
		hb_any = (prod_reg != 8'h00) || (wr_prod && CFG_WR.data[7:0] != 8'h00);
		for (int i = 0; i < NUM_CONS; i++)
			if (cons_reg[i][15:0] != 16'h0000)
				hb_any = 1'b1;
		if (wr_cons && CFG_WR.data[15:0] != 16'h0000)
			hb_any = 1'b1;
		cfg_conflict = (wr_guard && CFG_WR.data != 32'h0 && hb_any)
			|| (guard_on_reg && ((wr_cons && CFG_WR.data[15:0] != 16'h0000)
			|| (wr_prod && CFG_WR.data[7:0] != 8'h00)));
	end

	////////////////////////////////////////////////////////////////////////
	// Object storage

	// values return to defaults on SYS_RST
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			for (int i = 0; i < NUM_CONS; i++)
				cons_reg[i] <= `HBC_CONS_RESET;
			prod_reg     <= `HBC_PROD_RESET;
			guard_on_reg <= 1'b0;
		end
		else if (!cfg_conflict)
		begin
			if (wr_cons)
				cons_reg[wr_slot] <= {8'h00, CFG_WR.data[23:0]};
			if (wr_prod)
				prod_reg <= CFG_WR.data[7:0];
			if (wr_guard)
				guard_on_reg <= (CFG_WR.data != 32'h0);
		end
	end

	// Acknowledge and read-back of the written object's value from before the write
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			CFG_ACK   <= 1'b0;
			CFG_NAK   <= 1'b0;
			CFG_RDATA <= 32'h0000_0000;
		end
		else
		begin
			CFG_ACK   <= CFG_WR.valid && !wr_bad && !cfg_conflict;
			CFG_NAK   <= CFG_WR.valid && (wr_bad || cfg_conflict);
			if (CFG_WR.valid && CFG_WR.index == `HBC_IDX_CONSUMER && CFG_WR.sub == 8'h00)
				CFG_RDATA <= {24'h000000, `HBC_CONS_COUNT};
			else if (wr_cons)
				CFG_RDATA <= cons_reg[wr_slot];
			else if (wr_prod)
				CFG_RDATA <= {24'h000000, prod_reg};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Consumers

	// one engine per slot; no NMT state gates it
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			for (int i = 0; i < NUM_CONS; i++)
			begin
				cs_reg[i]   <= HBC_CS_OFF;
				ccnt_reg[i] <= 16'h0000;
			end
		end
		else
		begin
			for (int i = 0; i < NUM_CONS; i++)
			begin
				if (wr_cons && !cfg_conflict && wr_slot == 2'(i))
				begin
					// zero time disables, wait for first frame
					cs_reg[i]   <= (CFG_WR.data[15:0] == 16'h0000) ? HBC_CS_OFF : HBC_CS_WAIT;
					ccnt_reg[i] <= 16'h0000;
				end
				else
				begin
					case (cs_reg[i])
						HBC_CS_OFF: ;
						HBC_CS_WAIT:
						begin
							if (HB_RX.valid && HB_RX.node == cons_reg[i][22:16])
							begin
								cs_reg[i]   <= HBC_CS_RUN;
								ccnt_reg[i] <= 16'h0000;
							end
						end
						HBC_CS_RUN:
						begin
							if (HB_RX.valid && HB_RX.node == cons_reg[i][22:16])
								ccnt_reg[i] <= 16'h0000;
							else if (tick)
							begin
								if (ccnt_reg[i] + 16'h0001 >= cons_reg[i][15:0])
									cs_reg[i] <= HBC_CS_FAULT;
								ccnt_reg[i] <= ccnt_reg[i] + 16'h0001;
							end
						end
						HBC_CS_FAULT: ;
						default:
							cs_reg[i] <= HBC_CS_OFF;
					endcase
				end
			end
		end
	end

	// Error indication and preop request
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			COMM_ERROR  <= 1'b0;
			FORCE_PREOP <= 1'b0;
			CONS_FAULT  <= 4'h0;
		end
		else
		begin
			FORCE_PREOP <= 1'b0;
			for (int i = 0; i < NUM_CONS; i++)
			begin
				CONS_FAULT[i] <= (cs_reg[i] == HBC_CS_FAULT);
				if (cs_reg[i] == HBC_CS_RUN && tick && !(HB_RX.valid
					&& HB_RX.node == cons_reg[i][22:16])
					&& ccnt_reg[i] + 16'h0001 >= cons_reg[i][15:0])
					FORCE_PREOP <= 1'b1;
			end
			if (FORCE_PREOP)
				COMM_ERROR <= 1'b1;
			else if ((wr_cons || wr_prod) && !cfg_conflict)
				COMM_ERROR <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Producer

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			pcnt_reg    <= 8'h00;
			tx_pend_reg <= 1'b0;
			HB_TX       <= '0;
		end
		else
		begin
			HB_TX.valid <= 1'b0;
			if (prod_reg == 8'h00 || (wr_prod && !cfg_conflict))
				pcnt_reg <= 8'h00;
			else if (tick)
			begin
				if (pcnt_reg + 8'h01 >= prod_reg)
				begin
					pcnt_reg    <= 8'h00;
					tx_pend_reg <= 1'b1;
				end
				else
					pcnt_reg <= pcnt_reg + 8'h01;
			end
			if (tx_pend_reg && TX_READY && !HB_TX.valid)
			begin
				// frame 700h+node, bit7 zero; state code
				HB_TX.valid  <= 1'b1;
				HB_TX.cob_id <= `HBC_HB_COB_BASE + {4'h0, NODE_ID};
				HB_TX.data   <= {1'b0, state_code(NMT_STATE)};
				tx_pend_reg  <= 1'b0;
			end
		end
	end

endmodule

//--- sim/hbc_heartbeat_monitor.sv
`timescale 1ns/1ps
// Port-level checker for the heartbeat block
module hbc_heartbeat_monitor
	import hbc_pkg::*;
#(
	parameter logic [6:0] NODE_ID = 7'h01
)
(
	input wire logic       MCLK,
	input wire logic       SYS_RST,
	input wire hbc_cfg_t   CFG_WR,
	input wire hbc_tx_t    HB_TX,
	input wire logic       CFG_ACK,
	input wire logic       CFG_NAK,
	input wire logic       FORCE_PREOP,
	input wire logic       COMM_ERROR,
	input wire logic [3:0] CONS_FAULT
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	// Write strobe and its single answer
	sequence s_wr;
		CFG_WR.valid;
	endsequence
	sequence s_ans;
		CFG_ACK ^ CFG_NAK;
	endsequence
	chk_wr_answered: assert property (s_wr |=> s_ans)
		else $error("write not answered");
	chk_ans_cause: assert property ((CFG_ACK || CFG_NAK) |-> $past(CFG_WR.valid))
		else $error("answer without write");
	chk_tx_cob: assert property (HB_TX.valid |-> HB_TX.cob_id == 11'h700 + NODE_ID)
		else $error("bad frame id");
	chk_tx_bit7: assert property (HB_TX.valid |-> !HB_TX.data[7])
		else $error("bit 7 set");
	chk_tx_state: assert property (HB_TX.valid |-> HB_TX.data inside {8'h04, 8'h05, 8'h7F})
		else $error("bad state code");
	chk_tx_spaced: assert property (HB_TX.valid |=> !HB_TX.valid [*8])
		else $error("frames too close");
	chk_preop_err: assert property (FORCE_PREOP |=> COMM_ERROR)
		else $error("no error after timeout");
	chk_fault_err: assert property ($rose(|CONS_FAULT) |-> COMM_ERROR)
		else $error("fault without error");
	chk_err_clear: assert property ((CFG_ACK && $past(CFG_WR.index) == 16'h1017
		&& !FORCE_PREOP && !$past(FORCE_PREOP)) |-> !COMM_ERROR)
		else $error("error not cleared");
endmodule

bind hbc_heartbeat hbc_heartbeat_monitor #(.NODE_ID(NODE_ID)) u_mon (.MCLK(MCLK),
	.SYS_RST(SYS_RST), .CFG_WR(CFG_WR), .HB_TX(HB_TX), .CFG_ACK(CFG_ACK),
	.CFG_NAK(CFG_NAK), .FORCE_PREOP(FORCE_PREOP), .COMM_ERROR(COMM_ERROR),
	.CONS_FAULT(CONS_FAULT));

//--- sim/hbc_bus_model.sv
`timescale 1ns/1ps
// Other nodes on the bus: periodic heartbeats and a transmit gate
module hbc_bus_model
	import hbc_pkg::*;
#(
	parameter int TICK_CYCLES = 10
)
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       en,
	input wire logic [6:0] node,
	input wire logic       slow,
	output hbc_rx_t        hb_rx,
	output logic           tx_ready
);
	int         cnt_reg;   // Cycles since last frame
	logic [2:0] rdy_reg;   // Slow gate phase
	logic       fire;
	assign fire = en && cnt_reg == TICK_CYCLES - 1;
	// Frame period of one ms, counted only while enabled
	always_ff @(posedge clk)
	begin
		if (rst || !en || fire)
			cnt_reg <= 0;
		else
			cnt_reg <= cnt_reg + 1;
	end
	always_ff @(posedge clk)
	begin
		hb_rx.valid <= fire && !rst;
		// Idle field shows junk so a stale id never matches
		hb_rx.node <= fire ? node : ~node;
		// Gate phase starts known so the slow side never shows an unknown ready
		if (rst)
			rdy_reg <= 3'h0;
		else
			rdy_reg <= rdy_reg + 3'h1;
	end
	// Slow side accepts one cycle in eight
	assign tx_ready = !slow || rdy_reg == 3'h0;
endmodule

//--- sim/heartbeat_error_control_tb.sv
`timescale 1ns/1ps
module heartbeat_error_control_tb;
	import hbc_pkg::*;
	localparam int TK = 10;
	logic        MCLK, SYS_RST, TX_READY, CFG_ACK, CFG_NAK, FORCE_PREOP, COMM_ERROR;
	logic        m_en, m_slow;
	hbc_cfg_t    CFG_WR;
	hbc_rx_t     HB_RX;
	hbc_nmt_t    NMT_STATE;
	hbc_tx_t     HB_TX;
	logic [31:0] CFG_RDATA, seed, d;
	logic [3:0]  CONS_FAULT;
	logic [6:0]  m_node;
	logic [15:0] t;
	int          n_fail, samples_checked, n_tx, n_pre, cyc;
	hbc_heartbeat #(.TICK_CYCLES(TK), .NODE_ID(7'h01)) i_dut (.MCLK(MCLK), .SYS_RST(SYS_RST),
		.CFG_WR(CFG_WR), .HB_RX(HB_RX), .NMT_STATE(NMT_STATE), .TX_READY(TX_READY),
		.HB_TX(HB_TX), .CFG_ACK(CFG_ACK), .CFG_NAK(CFG_NAK), .CFG_RDATA(CFG_RDATA),
		.FORCE_PREOP(FORCE_PREOP), .COMM_ERROR(COMM_ERROR), .CONS_FAULT(CONS_FAULT));
	hbc_bus_model #(.TICK_CYCLES(TK)) i_bus (.clk(MCLK), .rst(SYS_RST), .en(m_en),
		.node(m_node), .slow(m_slow), .hb_rx(HB_RX), .tx_ready(TX_READY));
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected heartbeat byte for a network state
	function automatic logic [7:0] exp_st(input hbc_nmt_t s);
		return s == HBC_NMT_STOPPED ? 8'h04 : s == HBC_NMT_OPER ? 8'h05 : 8'h7F;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One write, answer seen the cycle after it is taken
	task automatic wr(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] v,
		input logic ok);
		@(posedge MCLK);
		CFG_WR <= {1'b1, ix, sb, v};
		@(posedge MCLK);
		CFG_WR.valid <= 1'b0;
		#1;
		chk({CFG_ACK, CFG_NAK}, {ok, !ok});
	endtask
	task automatic ms(input int n);
		repeat (n * TK) @(posedge MCLK);
		#1;
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	// Frame watcher and hang limit
	always @(posedge MCLK)
	begin
		cyc++;
		n_pre += (FORCE_PREOP === 1'b1);
		if (HB_TX.valid === 1'b1)
		begin
			n_tx++;
			chk(HB_TX.cob_id, 32'h701);
			chk(HB_TX.data, exp_st(NMT_STATE));
		end
		if (cyc > 20000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	initial
	begin
		{SYS_RST, CFG_WR, m_en, m_slow, m_node, seed} = {1'b1, 57'h0, 2'b0, 7'h0, 32'd22};
		NMT_STATE = HBC_NMT_PREOP;
		repeat (8) @(posedge MCLK);
		SYS_RST <= 1'b0;
		#1;
		chk({CONS_FAULT, COMM_ERROR, FORCE_PREOP}, 0);
		wr(16'h1016, 8'h00, 0, 0);
		chk(CFG_RDATA, 32'h4);
		wr(16'h1016, 8'h05, 32'h5000A, 0);
		wr(16'h1017, 8'h01, 32'h5, 0);
		wr(16'h1016, 8'h01, 32'h50001, 0);
		wr(16'h1017, 8'h00, 32'h1, 0);
		wr(16'h2000, 8'h00, 32'h5, 0);
		for (int i = 0; i < 4; i++)
		begin
			NMT_STATE <= hbc_nmt_t'(i % 3);
			m_node = rnd();
			t = 2 + rnd() % 4;
			d = {8'h00, 1'b0, m_node, t};
			wr(16'h1016, i + 1, d | 32'hA5000000, 1);
			m_node ^= 7'h01;
			m_en <= 1'b1;
			ms(t + 3);
			chk(CONS_FAULT, 0);
			m_node ^= 7'h01;
			ms(t + 3);
			chk(CONS_FAULT, 0);
			m_en <= 1'b0;
			n_pre = 0;
			ms(t + 2);
			chk({CONS_FAULT, COMM_ERROR, n_pre[3:0]}, {4'h1 << i, 1'b1, 4'h1});
			wr(16'h1016, i + 1, d & 32'hFFFF0000, 1);
			chk({COMM_ERROR, CFG_RDATA}, {1'b0, d});
			// Fault flags follow the slot state one cycle later
			@(posedge MCLK);
			#1;
			chk(CONS_FAULT, 0);
			m_en <= 1'b1;
			ms(2);
			m_en <= 1'b0;
			ms(t + 3);
			chk(CONS_FAULT, 0);
		end
		// Producer in every state, consumer live beside it
		wr(16'h100C, 8'h00, 32'h64, 1);
		wr(16'h1017, 8'h00, 32'h3, 0);
		wr(16'h100C, 8'h00, 32'h0, 1);
		m_node = 7'h05;
		wr(16'h1016, 8'h01, 32'h50004, 1);
		m_en <= 1'b1;
		for (int s = 0; s < 3; s++)
		begin
			NMT_STATE <= hbc_nmt_t'(s);
			m_slow <= s == 1;
			t = 2 + rnd() % 4;
			wr(16'h1017, 8'h00, t, 1);
			wr(16'h100C, 8'h00, 32'h64, 0);
			n_tx = 0;
			ms(10 * t);
			wr(16'h1017, 8'h00, 0, 1);
			ms(8);
			chk(n_tx >= 9 && n_tx <= 11, 1);
			chk(CONS_FAULT, 0);
		end
		n_tx = 0;
		ms(20);
		chk(n_tx, 0);
		print_verdict();
	end
endmodule
